// File: icr_pkg.sv
/*
 * shared constants and types of the program instruction cache.
 * assumes a 24-bit byte program address and a 32-bit register bus.
 */
package icr_pkg;
    localparam int ADDR_W      = 24;
    localparam int WORD_W      = 32;
    localparam int LINE_WORDS  = 4;
    localparam int LINE_W      = WORD_W * LINE_WORDS;
    localparam int WORD_LSB    = 2;
    localparam int IDX_LSB     = 4;
    localparam int WAY_IDX_W   = 9;
    localparam int WAY_TAG_W   = 11;
    localparam int WAY_TAG_LSB = 13;
    localparam int RS_IDX_W    = 8;
    localparam int RS_TAG_W    = 12;
    localparam int RS_TAG_LSB  = 12;
    localparam int NUM_BANKS   = 2;
    localparam int REG_AW      = 8;

    localparam logic [REG_AW-1:0] REG_CTRL    = 8'h00;
    localparam logic [REG_AW-1:0] REG_RS_TAG0 = 8'h04;
    localparam logic [REG_AW-1:0] REG_RS_TAG1 = 8'h08;
    localparam logic [REG_AW-1:0] REG_STATUS  = 8'h0C;
    localparam logic [REG_AW-1:0] REG_INVAL   = 8'h10;

    localparam int CTRL_ON      = 0;
    localparam int CTRL_WIPE    = 1;
    localparam int CTRL_LOCK    = 2;
    localparam int CTRL_TWO_WAY = 3;
    localparam int CTRL_WAY_EN  = 4;
    localparam int CTRL_RS0_EN  = 5;
    localparam int CTRL_RS1_EN  = 6;

    localparam int ST_TVB0      = 0;
    localparam int ST_BUSY      = 2;
    localparam int ST_WAY0_FULL = 3;

    localparam logic [1:0] LAST_WORD = 2'h3;

    typedef enum logic [1:0] {ICR_IDLE, ICR_FILL, ICR_BYP} icr_state_t;
endpackage

// File: icr_bank_if.sv
/*
 * lookup, write and invalidate bundle between the cache control and
 * one storage bank. assumes a single clock shared by both sides.
 */
`timescale 1ns/1ps
interface icr_bank_if #(
    parameter int IDX_W = 9,
    parameter int TAG_W = 11
);
    import icr_pkg::*;
    logic [IDX_W-1:0]  rd_idx;
    logic [TAG_W-1:0]  rd_tag;
    logic              rd_lv;
    logic [LINE_W-1:0] rd_line;
    logic              blk_full;
    logic              tag_ok;
    logic              wr_en;
    logic [IDX_W-1:0]  wr_idx;
    logic [TAG_W-1:0]  wr_tag;
    logic              tag_we;
    logic [LINE_W-1:0] wr_line;
    logic              inv_all;
    logic              inv_en;
    logic [IDX_W-1:0]  inv_idx;
    modport bank (input rd_idx, wr_en, wr_idx, wr_tag, tag_we, wr_line, inv_all, inv_en,
                  input inv_idx, output rd_tag, rd_lv, rd_line, blk_full, tag_ok);
    modport ctl (output rd_idx, wr_en, wr_idx, wr_tag, tag_we, wr_line, inv_all, inv_en,
                 output inv_idx, input rd_tag, rd_lv, rd_line, blk_full, tag_ok);
endinterface

// File: icr_way.sv
/*
 * one cache way: line data, per-line tag and line_valid_flag.
 * assumes the controller gives one write per cycle at most.
 */
`timescale 1ns/1ps
module icr_way
    import icr_pkg::*;
#(
    parameter int IDX_W = WAY_IDX_W,
    parameter int TAG_W = WAY_TAG_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    icr_bank_if.bank b
);
    localparam int DEPTH = 1 << IDX_W;
    typedef struct packed {
        logic [DEPTH-1:0][LINE_W-1:0] data;
        logic [DEPTH-1:0][TAG_W-1:0]  tag;
        logic [DEPTH-1:0]             lv;
    } icr_way_st_t;
    icr_way_st_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (b.inv_all) begin
            st_d.lv = '0;
        end
        if (b.inv_en) begin
            st_d.lv[b.inv_idx] = 1'b0;
        end
        if (b.wr_en) begin
            st_d.data[b.wr_idx] = b.wr_line;
            st_d.tag[b.wr_idx]  = b.wr_tag;
            st_d.lv[b.wr_idx]   = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign b.rd_tag   = st_q.tag[b.rd_idx];
    assign b.rd_lv    = st_q.lv[b.rd_idx];
    assign b.rd_line  = st_q.data[b.rd_idx];
    assign b.blk_full = &st_q.lv;
    assign b.tag_ok   = 1'b1;
endmodule

// File: icr_half.sv
/*
 * one half ramset: 256 lines under a single block tag with its
 * block_tag_valid_flag. assumes the controller fills it line by line.
 */
`timescale 1ns/1ps
module icr_half
    import icr_pkg::*;
#(
    parameter int IDX_W = RS_IDX_W,
    parameter int TAG_W = RS_TAG_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    icr_bank_if.bank b
);
    localparam int DEPTH = 1 << IDX_W;
    typedef struct packed {
        logic [DEPTH-1:0][LINE_W-1:0] data;
        logic [DEPTH-1:0]             lv;
        logic [TAG_W-1:0]             tag;
        logic                         tag_set;
        logic                         block_tag_valid_flag;
    } icr_half_st_t;
    icr_half_st_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (b.tag_we) begin
            st_d.tag     = b.wr_tag;
            st_d.tag_set = 1'b1;
            st_d.lv      = '0;
        end
        if (b.inv_all) begin
            st_d.lv = '0;
        end
        if (b.inv_en) begin
            st_d.lv[b.inv_idx] = 1'b0;
        end
        if (b.wr_en) begin
            st_d.data[b.wr_idx] = b.wr_line;
            st_d.lv[b.wr_idx]   = 1'b1;
        end
        st_d.block_tag_valid_flag = st_d.tag_set & (&st_d.lv);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign b.rd_tag   = st_q.tag;
    assign b.rd_lv    = st_q.lv[b.rd_idx];
    assign b.rd_line  = st_q.data[b.rd_idx];
    assign b.blk_full = st_q.block_tag_valid_flag;
    assign b.tag_ok   = st_q.tag_set;
endmodule

// File: icr_top.sv
/*
 * program instruction cache: two ways, two half ramsets, line buffer,
 * burst fill engine and AHB-Lite register slave.
 * assumes fetch_addr is held until fetch_ready, and the memory port
 * answers a held mem_req with one word per mem_rvalid.
 */
`timescale 1ns/1ps
// What this block does
// - 24K bytes: two 8K ways plus two separate 4K half ramsets.
// - two-way or direct-mapped, each with zero, one or two halves.
// - disabled after reset; ramset serves only once software set it up.
// - all external addresses cacheable; internal ones bypass the cache.
// - hit outside the buffered line waits one cycle; hits within the buffered line wait none.
// - one aligned 32-bit word per fetch.
// - miss fetches the line as a four-word burst, stalling the fetch.
// - wanted word goes to the cpu as soon as it arrives.
// - fetch to a line being filled waits for its word, no new burst.
// - lines whose external contents changed are invalidated.
// - each way holds 512 four-word lines with tag and valid flag.
// - way address split: 4-bit byte, 9-bit index, 11-bit tag.
// - half ramset: 256 lines, 8-bit index, one 12-bit block tag.
// - enable or flush clears all line valid flags; clear flag means miss.
// - two-way lru bit names the way not hit last; toggled after refill.
// - block tag valid clears on enable or flush, sets when half is full.
// - ramset fill requests beat cpu fetches.
// - fetch address decoded to cache or internal memory.
// - hit needs tag match and valid line; word field picks the word.
// - ramset and cache checked together; ramset hit wins.
// - both miss loads cache line; only cache hit reads cache.
// - ramset tag match with invalid line loads the ramset line.
// - requested word returned mid-fill; flags updated only after fill.
// - with cache off, fetches go straight to memory.
// - wipe bit self-clears after all blocks are invalidated.
// - lock bit stops way miss updates but not ramset line loads; hits still served.
module icr_top
    import icr_pkg::*;
#(
    parameter logic [ADDR_W-1:0] INT_LIMIT = 24'h050000
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              fetch_req,
    input  wire logic [ADDR_W-1:0] fetch_addr,
    output logic                   fetch_ready,
    output logic [WORD_W-1:0]      fetch_data,
    output logic                   int_req,
    output logic                   mem_req,
    output logic                   mem_burst,
    output logic [ADDR_W-1:0]      mem_addr,
    input  wire logic              mem_rvalid,
    input  wire logic [WORD_W-1:0] mem_rdata
);
    typedef struct packed {
        icr_state_t                          st;
        logic                                on;
        logic                                wipe;
        logic                                lock;
        logic                                two_way;
        logic                                way_en;
        logic [NUM_BANKS-1:0]                rs_en;
        logic                                ap_wr;
        logic [REG_AW-1:0]                   ap_addr;
        logic [31:0]                         rdata;
        logic [ADDR_W-1:IDX_LSB]             lb_line;
        logic [LINE_WORDS-1:0]               lb_wv;
        logic [LINE_WORDS-1:0][WORD_W-1:0]   lb_data;
        logic                                lb_byp;
        logic [1:0]                          cnt;
        logic [1:0]                          tgt;
        logic                                tgt_wr;
        logic [RS_IDX_W-1:0]                 scan;
        logic [(1<<WAY_IDX_W)-1:0]           lru;
    } icr_top_st_t;
    icr_top_st_t st_q, st_d;

    icr_bank_if #(.IDX_W(WAY_IDX_W), .TAG_W(WAY_TAG_W)) wif [NUM_BANKS] ();
    icr_bank_if #(.IDX_W(RS_IDX_W), .TAG_W(RS_TAG_W))   rif [NUM_BANKS] ();

    logic [NUM_BANKS-1:0][WAY_TAG_W-1:0] way_tag;
    logic [NUM_BANKS-1:0][LINE_W-1:0]    way_line;
    logic [NUM_BANKS-1:0]                way_lv;
    logic [NUM_BANKS-1:0]                way_full;
    logic [NUM_BANKS-1:0][RS_TAG_W-1:0]  rs_tag;
    logic [NUM_BANKS-1:0][LINE_W-1:0]    rs_line;
    logic [NUM_BANKS-1:0]                rs_lv;
    logic [NUM_BANKS-1:0]                rs_full;
    logic [NUM_BANKS-1:0]                rs_tag_ok;
    logic [NUM_BANKS-1:0]                way_hit;
    logic [NUM_BANKS-1:0]                rs_tmatch;
    logic [NUM_BANKS-1:0]                rs_pend;
    logic [NUM_BANKS-1:0]                way_we;
    logic [NUM_BANKS-1:0]                rs_we;
    logic [NUM_BANKS-1:0]                rs_tag_we;
    logic [NUM_BANKS-1:0]                rs_inv_all;
    logic                                way_inv_all;
    logic                                inv_en;
    logic [ADDR_W-1:0]                   inv_a;
    logic [LINE_WORDS-1:0][WORD_W-1:0]   fill_line;
    logic                                f_ext;
    logic                                lb_hit;
    logic                                scan_on;
    logic                                scan_h;
    logic [1:0]                          f_word;
    logic [WAY_IDX_W-1:0]                f_idx;

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        icr_way u_way (
            .hclk    (hclk),
            .hresetn (hresetn),
            .b       (wif[g])
        );
        icr_half u_half (
            .hclk    (hclk),
            .hresetn (hresetn),
            .b       (rif[g])
        );
        assign wif[g].rd_idx  = f_idx;
        assign wif[g].wr_en   = way_we[g];
        assign wif[g].wr_idx  = st_q.lb_line[WAY_TAG_LSB-1:IDX_LSB];
        assign wif[g].wr_tag  = st_q.lb_line[ADDR_W-1:WAY_TAG_LSB];
        assign wif[g].tag_we  = 1'b0;
        assign wif[g].wr_line = fill_line;
        assign wif[g].inv_all = way_inv_all;
        assign wif[g].inv_en  = inv_en;
        assign wif[g].inv_idx = inv_a[WAY_TAG_LSB-1:IDX_LSB];
        assign way_tag[g]     = wif[g].rd_tag;
        assign way_lv[g]      = wif[g].rd_lv;
        assign way_line[g]    = wif[g].rd_line;
        assign way_full[g]    = wif[g].blk_full;
        assign rif[g].rd_idx  = scan_on ? st_q.scan : fetch_addr[RS_TAG_LSB-1:IDX_LSB];
        assign rif[g].wr_en   = rs_we[g];
        assign rif[g].wr_idx  = st_q.lb_line[RS_TAG_LSB-1:IDX_LSB];
        assign rif[g].wr_tag  = hwdata[RS_TAG_W-1:0];
        assign rif[g].tag_we  = rs_tag_we[g];
        assign rif[g].wr_line = fill_line;
        assign rif[g].inv_all = rs_inv_all[g];
        assign rif[g].inv_en  = inv_en && (inv_a[ADDR_W-1:RS_TAG_LSB] == rs_tag[g]);
        assign rif[g].inv_idx = inv_a[RS_TAG_LSB-1:IDX_LSB];
        assign rs_tag[g]      = rif[g].rd_tag;
        assign rs_lv[g]       = rif[g].rd_lv;
        assign rs_line[g]     = rif[g].rd_line;
        assign rs_full[g]     = rif[g].blk_full;
        assign rs_tag_ok[g]   = rif[g].tag_ok;
        assign way_hit[g]   = st_q.way_en && (g == 0 || st_q.two_way) && way_lv[g]
                              && way_tag[g] == fetch_addr[ADDR_W-1:WAY_TAG_LSB];
        assign rs_tmatch[g] = st_q.rs_en[g] && rs_tag_ok[g]
                              && rs_tag[g] == fetch_addr[ADDR_W-1:RS_TAG_LSB];
        assign rs_pend[g]   = st_q.rs_en[g] && rs_tag_ok[g] && !rs_full[g];
        assign fill_line[g] = (mem_rvalid && st_q.cnt == 2'(g)) ? mem_rdata : st_q.lb_data[g];
        assign fill_line[g+NUM_BANKS] = (mem_rvalid && st_q.cnt == 2'(g + NUM_BANKS))
                                        ? mem_rdata : st_q.lb_data[g+NUM_BANKS];
    end

    assign f_word  = fetch_addr[IDX_LSB-1:WORD_LSB];
    assign f_idx   = fetch_addr[WAY_TAG_LSB-1:IDX_LSB];
    assign f_ext   = fetch_req && fetch_addr >= INT_LIMIT;
    assign int_req = fetch_req && fetch_addr < INT_LIMIT;
    assign scan_on = st_q.on && (|rs_pend) && st_q.st == ICR_IDLE;
    assign scan_h  = !rs_pend[0];
    assign lb_hit  = f_ext && st_q.lb_line == fetch_addr[ADDR_W-1:IDX_LSB]
                     && st_q.lb_wv[f_word] && (st_q.on || st_q.lb_byp);

    assign fetch_ready = lb_hit;
    assign fetch_data  = st_q.lb_data[f_word];
    assign mem_req     = st_q.st != ICR_IDLE;
    assign mem_burst   = st_q.st == ICR_FILL;
    assign mem_addr    = mem_burst ? {st_q.lb_line, 4'h0} : {st_q.lb_line, st_q.cnt, 2'h0};
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = st_q.rdata;
    assign inv_a       = hwdata[ADDR_W-1:0];
    assign inv_en      = st_q.ap_wr && st_q.ap_addr == REG_INVAL;

    always_comb begin
        st_d        = st_q;
        way_we      = '0;
        rs_we       = '0;
        rs_tag_we   = '0;
        rs_inv_all  = '0;
        way_inv_all = 1'b0;
        if (st_q.wipe) begin
            way_inv_all = 1'b1;
            rs_inv_all  = '1;
            st_d.wipe   = 1'b0;
        end
        if (st_q.ap_wr) begin
            case (st_q.ap_addr)
                REG_CTRL: begin
                    if (hwdata[CTRL_ON] && !st_q.on) begin
                        way_inv_all = 1'b1;
                        rs_inv_all  = '1;
                    end
                    for (int h = 0; h < NUM_BANKS; h++) begin
                        if (hwdata[CTRL_RS0_EN+h] && !st_q.rs_en[h]) begin
                            rs_inv_all[h] = 1'b1;
                        end
                    end
                    st_d.on      = hwdata[CTRL_ON];
                    st_d.wipe    = hwdata[CTRL_WIPE];
                    st_d.lock    = hwdata[CTRL_LOCK];
                    st_d.two_way = hwdata[CTRL_TWO_WAY];
                    st_d.way_en  = hwdata[CTRL_WAY_EN];
                    st_d.rs_en   = hwdata[CTRL_RS1_EN:CTRL_RS0_EN];
                end
                REG_RS_TAG0: rs_tag_we[0] = 1'b1;
                REG_RS_TAG1: rs_tag_we[1] = 1'b1;
                default: ;
            endcase
        end
        if (way_inv_all || inv_en || (|rs_inv_all)) begin
            st_d.lb_wv = '0;
        end
        st_d.ap_wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            st_d.ap_wr   = hwrite;
            st_d.ap_addr = haddr[REG_AW-1:0];
            if (!hwrite) begin
                case (haddr[REG_AW-1:0])
                    REG_CTRL: st_d.rdata = 32'({st_q.rs_en, st_q.way_en, st_q.two_way,
                                                st_q.lock, st_q.wipe, st_q.on});
                    REG_RS_TAG0: st_d.rdata = 32'(rs_tag[0]);
                    REG_RS_TAG1: st_d.rdata = 32'(rs_tag[1]);
                    REG_STATUS: st_d.rdata = 32'({way_full, st_q.st != ICR_IDLE,
                                                  rs_full}) << ST_TVB0;
                    default: st_d.rdata = '0;
                endcase
            end
        end
        if (lb_hit && !st_q.on) begin
            st_d.lb_wv  = '0;
            st_d.lb_byp = 1'b0;
        end
        case (st_q.st)
            ICR_IDLE: begin
                if (scan_on) begin
                    if (rs_lv[scan_h]) begin
                        st_d.scan = st_q.scan + 1'b1;
                    end else begin
                        st_d.st      = ICR_FILL;
                        st_d.tgt     = {1'b1, scan_h};
                        st_d.tgt_wr  = 1'b1;
                        st_d.lb_line = {rs_tag[scan_h], st_q.scan};
                        st_d.lb_wv   = '0;
                        st_d.cnt     = '0;
                    end
                end else if (f_ext && !lb_hit) begin
                    st_d.lb_line = fetch_addr[ADDR_W-1:IDX_LSB];
                    st_d.lb_wv   = '0;
                    st_d.cnt     = '0;
                    if (!st_q.on) begin
                        st_d.st     = ICR_BYP;
                        st_d.cnt    = f_word;
                        st_d.lb_byp = 1'b1;
                    end else if (rs_tmatch[0] && rs_lv[0]) begin
                        st_d.lb_data = rs_line[0];
                        st_d.lb_wv   = '1;
                    end else if (rs_tmatch[1] && rs_lv[1]) begin
                        st_d.lb_data = rs_line[1];
                        st_d.lb_wv   = '1;
                    end else if (|rs_tmatch) begin
                        st_d.st     = ICR_FILL;
                        st_d.tgt    = {1'b1, !rs_tmatch[0]};
                        st_d.tgt_wr = 1'b1;
                    end else if (|way_hit) begin
                        st_d.lb_data    = way_line[way_hit[1]];
                        st_d.lb_wv      = '1;
                        st_d.lru[f_idx] = !way_hit[1];
                    end else begin
                        st_d.st     = ICR_FILL;
                        st_d.tgt    = {1'b0, st_q.two_way && st_q.lru[f_idx]};
                        st_d.tgt_wr = !st_q.lock && st_q.way_en;
                    end
                end
            end
            ICR_FILL: begin
                if (mem_rvalid) begin
                    st_d.lb_data[st_q.cnt] = mem_rdata;
                    st_d.lb_wv[st_q.cnt]   = 1'b1;
                    st_d.cnt               = st_q.cnt + 1'b1;
                    if (st_q.cnt == LAST_WORD) begin
                        st_d.st = ICR_IDLE;
                        if (st_q.tgt_wr && st_q.tgt[1]) begin
                            rs_we[st_q.tgt[0]] = 1'b1;
                        end else if (st_q.tgt_wr) begin
                            way_we[st_q.tgt[0]] = 1'b1;
                            if (st_q.two_way) begin
                                st_d.lru[st_q.lb_line[WAY_TAG_LSB-1:IDX_LSB]] =
                                    !st_q.lru[st_q.lb_line[WAY_TAG_LSB-1:IDX_LSB]];
                            end
                        end
                    end
                end
            end
            ICR_BYP: begin
                if (mem_rvalid) begin
                    st_d.lb_data[st_q.cnt] = mem_rdata;
                    st_d.lb_wv[st_q.cnt]   = 1'b1;
                    st_d.st                = ICR_IDLE;
                end
            end
            default: st_d.st = ICR_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// File: icr_top_props.sv
/* port assertions for the instruction cache top.
   assumes one clock domain and one bus master. */
`timescale 1ns/1ps
module icr_props
    import icr_pkg::*;
#(parameter logic [ADDR_W-1:0] INT_LIMIT = 24'h050000) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              fetch_req,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic              fetch_ready,
    input wire logic              int_req,
    input wire logic              mem_req,
    input wire logic              mem_burst,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_rvalid
);
    logic       wr_q;
    logic       on_q;
    logic [2:0] beats_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            on_q    <= 1'b0;
            beats_q <= 3'h0;
        end else begin
            wr_q    <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == REG_CTRL;
            on_q    <= wr_q ? hwdata[CTRL_ON] : on_q;
            beats_q <= !mem_req ? 3'h0 : beats_q + 3'(mem_rvalid);
        end
    end
    AST_OFF_SINGLE: assert property (
        $rose(mem_req) && !on_q |-> !mem_burst) else $error("off burst");
    AST_INT_ROUTE: assert property (
        fetch_req && fetch_addr < INT_LIMIT |-> int_req && !fetch_ready) else $error("int route");
    AST_EXT_ROUTE: assert property (
        fetch_req && fetch_addr >= INT_LIMIT |-> !int_req) else $error("ext route");
    AST_LINE_BASE: assert property (
        mem_req && mem_burst |-> mem_addr[3:0] == 4'h0) else $error("burst base");
    AST_ADDR_HOLD: assert property (
        mem_req && $past(mem_req) |-> $stable(mem_addr) && $stable(mem_burst)) else $error("hold");
    AST_BEATS: assert property (
        $fell(mem_req) |-> beats_q == ($past(mem_burst) ? 3'h4 : 3'h1)) else $error("beats");
    AST_NO_REBURST: assert property (
        mem_req |-> beats_q < 3'h4) else $error("reburst");
    AST_PROMPT: assert property (
        fetch_req && !int_req && !mem_req |-> ##[0:2] (fetch_ready || mem_req)) else $error("slow");
    cover property ($fell(mem_req) && beats_q == 3'h4);
    cover property (int_req);
    cover property (fetch_ready && !mem_req && !$past(fetch_ready));
endmodule

// File: icr_mem_model.sv
/* external memory model: one word every other cycle, word is 5A over
   its byte address. assumes mem_req held as the design promises. */
`timescale 1ns/1ps
module icr_mem_model
    import icr_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              mem_req,
    input wire logic              mem_burst,
    input wire logic [ADDR_W-1:0] mem_addr,
    output logic                  mem_rvalid,
    output logic [WORD_W-1:0]     mem_rdata
);
    logic [2:0] n_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_q        <= 3'h0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 32'h0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            if (!mem_req) begin
                n_q <= 3'h0;
            end else if (!mem_rvalid && n_q < (mem_burst ? 3'h4 : 3'h1)) begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= {8'h5A, mem_addr + {n_q, 2'h0}};
                n_q        <= n_q + 3'h1;
            end
        end
    end
endmodule

// File: tb_dsp_instruction_cache_ramset.sv
/* self-checking bench of the instruction cache top.
   assumes the default internal limit and the memory model. */
`timescale 1ns/1ps
module tb_dsp_instruction_cache_ramset;
    import icr_pkg::*;
    localparam logic [23:0] LA = 24'h123450;
    localparam logic [23:0] LB = 24'h125450;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        fetch_req, fetch_ready, int_req, mem_req, mem_burst, mem_rvalid;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, mem_rdata, fetch_data, rd;
    logic [23:0] fetch_addr, mem_addr;
    int          n_mismatch = 0, num_checks = 0, cyc = 0;
    icr_top icr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
        .int_req(int_req), .mem_req(mem_req), .mem_burst(mem_burst), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    icr_mem_model icr_mem_model_i (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
        .mem_burst(mem_burst), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic fetch(input logic [23:0] a, input logic [1:0] exp_m, input int exp_w);
        int         w = 0;
        logic [1:0] m = 2'h0;
        while (exp_w > 0 && mem_req) @(posedge hclk);
        fetch_req  <= 1'b1;
        fetch_addr <= a;
        do begin
            @(posedge hclk);
            w++;
            m |= {mem_req & mem_burst, mem_req};
        end while (fetch_ready !== 1'b1 && w < 100);
        chk(fetch_data, {8'h5A, a});
        chk(32'(m), 32'(exp_m));
        if (exp_w > 0) chk(32'(w), 32'(exp_w));
        fetch_req <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic t_off;
        ahb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        fetch_req  <= 1'b1;
        fetch_addr <= 24'h001000;
        @(posedge hclk);
        chk(32'({hresp, int_req, fetch_ready, mem_req}), 32'h4);
        fetch_req <= 1'b0;
        @(posedge hclk);
        fetch(LA, 2'h1, 0);
        $display("test off done");
    endtask
    task automatic t_ways;
        ahb(1'b1, REG_CTRL, 32'h19);
        fetch(LA + 24'h8, 2'h3, 0);
        fetch(LA + 24'hC, 2'h0, 1);
        fetch(LA + 24'h10, 2'h3, 0);
        fetch(LA, 2'h0, 2);
        fetch(LB, 2'h3, 0);
        fetch(LA, 2'h0, 2);
        fetch(LB + 24'h4, 2'h0, 2);
        ahb(1'b1, REG_INVAL, {8'h0, LA});
        fetch(LA, 2'h3, 0);
        ahb(1'b1, REG_CTRL, 32'h11);
        fetch(LB, 2'h3, 0);
        fetch(LA, 2'h3, 0);
        ahb(1'b1, REG_CTRL, 32'h1B);
        repeat (2) @(posedge hclk);
        ahb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h19);
        fetch(LA + 24'h10, 2'h3, 0);
        $display("test ways done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, fetch_req, fetch_addr} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_off();
        t_ways();
        report_and_stop();
    end
endmodule
bind icr_top icr_props #(.INT_LIMIT(INT_LIMIT)) icr_props_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .int_req(int_req), .mem_req(mem_req),
    .mem_burst(mem_burst), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid));
